// >>> ppm_regs.vh
// constants for the parallel pin group multiplexer
`ifndef PPM_REGS_VH
`define PPM_REGS_VH

// pin group widths
`define PPM_ADDR_W 20
`define PPM_DATA_W 32
`define PPM_CTRL_W 16
`define PPM_GPIO_W 36
`define PPM_HOST_W 16
`define PPM_HOST_CTRL_W 9

// mode bit values held in the bus selection register
`define PPM_MODE_HOST_NONMUX 1'b0
`define PPM_MODE_FULL_MEM 1'b1
`define PPM_MODE_RESET 1'b1

// control pin functions in full memory mode
`define PPM_CTL_SHARED_READ_STROBE 0
`define PPM_CTL_SHARED_OUTPUT_ENABLE 1
`define PPM_CTL_SHARED_WRITE_ENABLE 2
`define PPM_CTL_ASYNC_READY 3
`define PPM_CTL_CHIP_ENABLE_ZERO 4
`define PPM_CTL_BYTE_ENABLE_ZERO 8
`define PPM_CTL_MEMORY_CLOCK_ENABLE 12
`define PPM_CTL_FOURTH_OUTPUT_ENABLE 13
`define PPM_CTL_HOLD_REQUEST 14
`define PPM_CTL_HOLD_ACKNOWLEDGE 15

// parallel general io bit positions in host mode
`define PPM_GPIO_ADDR_LSB 0
`define PPM_GPIO_DATA_LSB 4
`define PPM_GPIO_CTRL_LSB 20

// synchroniser depth
`define PPM_SYNC_STAGES 2

`endif

// >>> ppm_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ppm_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge core_clk) begin
    meta <= async_in;
    sync_out <= meta;
  end

endmodule // ppm_sync

// >>> ppm_parallel_mux.v
// parallel pin group multiplexer, strap-selected at reset
//
// Summary of operation
// - routing comes only from the host strap level seen during reset.
// - only the host strap sets the muxes at reset; both mode bits then report the straps.
// - mux covers address pins 2..21, data pins 0..31, control 0..15.
// - strap low: memory interface off, host address/data on low pins.
// - host mode gives host port 16 address, 16 data, 9 controls.
// - host mode: leftover address, data, control pins go to general io.
// - strap low clears the parallel/host mode bit.
// - strap high: memory interface owns all address, data, control pins.
// - control pins carry memory strobes, enables, ready, hold in order.
// - strap high: host port runs multiplexed over its sixteen data pins.
// - strap high sets the parallel/host mode bit to one.
// - memory interface clock is gated off while it is deselected.
// - access to deselected memory interface errors when timeout enabled.
`timescale 1ns/100ps
`include "ppm_regs.vh"
module ppm_parallel_mux #(
  parameter ADDR_W = `PPM_ADDR_W,
  parameter DATA_W = `PPM_DATA_W,
  parameter CTRL_W = `PPM_CTRL_W,
  parameter GPIO_W = `PPM_GPIO_W
) (
  input wire core_clk,
  input wire reset_n,
  input wire host_config_strap,
  input wire serial_config_strap,
  // address pins 21..2
  input wire [ADDR_W-1:0] addr_pin_in,
  output reg [ADDR_W-1:0] addr_pin_out,
  output reg [ADDR_W-1:0] addr_pin_oe_n,
  // data pins 31..0
  input wire [DATA_W-1:0] data_pin_in,
  output reg [DATA_W-1:0] data_pin_out,
  output reg [DATA_W-1:0] data_pin_oe_n,
  // control pins 15..0
  input wire [CTRL_W-1:0] ctrl_pin_in,
  output reg [CTRL_W-1:0] ctrl_pin_out,
  output reg [CTRL_W-1:0] ctrl_pin_oe_n,
  // external memory interface side
  input wire [ADDR_W-1:0] mem_addr,
  input wire [ADDR_W-1:0] mem_addr_oe_n,
  input wire [DATA_W-1:0] mem_data_out,
  input wire [DATA_W-1:0] mem_data_oe_n,
  output reg [DATA_W-1:0] mem_data_in,
  input wire [CTRL_W-1:0] mem_ctrl_out,
  input wire [CTRL_W-1:0] mem_ctrl_oe_n,
  output reg [CTRL_W-1:0] mem_ctrl_in,
  input wire mem_access_req,
  input wire peripheral_timeout_enable,
  output reg mem_bus_error,
  output reg mem_clk_enable,
  output reg mem_enable,
  // host port side, non-multiplexed path
  output reg [`PPM_HOST_W-1:0] host_address_bits,
  input wire [`PPM_HOST_W-1:0] host_data_out,
  input wire host_data_oe_n,
  output reg [`PPM_HOST_W-1:0] host_data_bits,
  input wire [`PPM_HOST_CTRL_W-1:0] host_ctrl_pin_in,
  output reg [`PPM_HOST_CTRL_W-1:0] host_ctrl,
  output reg host_port_enable,
  output reg host_mux_mode,
  // parallel general io side
  input wire [GPIO_W-1:0] parallel_general_io_out,
  input wire [GPIO_W-1:0] parallel_general_io_oe_n,
  output reg [GPIO_W-1:0] parallel_general_io_in,
  // bus selection register mode bits
  output reg bus_sel_parallel_mode,
  output reg bus_sel_serial_mode
);

  localparam HW = `PPM_HOST_W;
  localparam GA = `PPM_GPIO_ADDR_LSB;
  localparam GD = `PPM_GPIO_DATA_LSB;
  localparam GC = `PPM_GPIO_CTRL_LSB;

  wire host_strap_sync;
  wire serial_strap_sync;
  wire [ADDR_W-1:0] addr_sync;
  wire [DATA_W-1:0] data_sync;
  wire [CTRL_W-1:0] ctrl_sync;
  wire [`PPM_HOST_CTRL_W-1:0] host_ctrl_sync;

  reg mode_full;
  reg [ADDR_W-1:0] next_addr_out;
  reg [ADDR_W-1:0] next_addr_oe_n;
  reg [DATA_W-1:0] next_data_out;
  reg [DATA_W-1:0] next_data_oe_n;
  reg [CTRL_W-1:0] next_ctrl_out;
  reg [CTRL_W-1:0] next_ctrl_oe_n;
  reg [GPIO_W-1:0] next_gpio_in;

  // pick one of two equal-width words by the full-memory mode
  function [DATA_W-1:0] pick;
    input sel_full;
    input [DATA_W-1:0] full_val;
    input [DATA_W-1:0] host_val;
    begin
      pick = sel_full ? full_val : host_val;
    end
  endfunction

  ppm_sync #(.WIDTH(2)) u_strap_sync (
    .core_clk(core_clk),
    .async_in({host_config_strap, serial_config_strap}),
    .sync_out({host_strap_sync, serial_strap_sync})
  );

  ppm_sync #(.WIDTH(ADDR_W)) u_addr_sync (
    .core_clk(core_clk),
    .async_in(addr_pin_in),
    .sync_out(addr_sync)
  );

  ppm_sync #(.WIDTH(DATA_W)) u_data_sync (
    .core_clk(core_clk),
    .async_in(data_pin_in),
    .sync_out(data_sync)
  );

  ppm_sync #(.WIDTH(CTRL_W)) u_ctrl_sync (
    .core_clk(core_clk),
    .async_in(ctrl_pin_in),
    .sync_out(ctrl_sync)
  );

  ppm_sync #(.WIDTH(`PPM_HOST_CTRL_W)) u_hctl_sync (
    .core_clk(core_clk),
    .async_in(host_ctrl_pin_in),
    .sync_out(host_ctrl_sync)
  );

  // straps are caught while reset is held and frozen after release
  always @(posedge core_clk) begin
    if (!reset_n) begin
      mode_full <= host_strap_sync;
      bus_sel_parallel_mode <= host_strap_sync;
      bus_sel_serial_mode <= serial_strap_sync;
    end
  end

  // pin-side routing
  always @* begin
    next_addr_out = mem_addr;
    next_addr_oe_n = mem_addr_oe_n;
    next_data_out = mem_data_out;
    next_data_oe_n = mem_data_oe_n;
    next_ctrl_out = mem_ctrl_out;
    next_ctrl_oe_n = mem_ctrl_oe_n;
    if (mode_full == `PPM_MODE_HOST_NONMUX) begin
      // host drives address in; low address pins are inputs
      next_addr_out[HW-1:0] = {HW{1'b0}};
      next_addr_oe_n[HW-1:0] = {HW{1'b1}};
      next_addr_out[ADDR_W-1:HW] = parallel_general_io_out[GD-1:GA];
      next_addr_oe_n[ADDR_W-1:HW] = parallel_general_io_oe_n[GD-1:GA];
      next_data_out[HW-1:0] = host_data_out;
      next_data_oe_n[HW-1:0] = {HW{host_data_oe_n}};
      next_data_out[DATA_W-1:HW] = parallel_general_io_out[GC-1:GD];
      next_data_oe_n[DATA_W-1:HW] = parallel_general_io_oe_n[GC-1:GD];
      next_ctrl_out = parallel_general_io_out[GPIO_W-1:GC];
      next_ctrl_oe_n = parallel_general_io_oe_n[GPIO_W-1:GC];
    end
  end

  // core-side routing of synchronised pin levels
  always @* begin
    next_gpio_in = {GPIO_W{1'b0}};
    if (mode_full == `PPM_MODE_HOST_NONMUX) begin
      next_gpio_in[GD-1:GA] = addr_sync[ADDR_W-1:HW];
      next_gpio_in[GC-1:GD] = data_sync[DATA_W-1:HW];
      next_gpio_in[GPIO_W-1:GC] = ctrl_sync;
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      addr_pin_out <= {ADDR_W{1'b0}};
      addr_pin_oe_n <= {ADDR_W{1'b1}};
      data_pin_out <= {DATA_W{1'b0}};
      data_pin_oe_n <= {DATA_W{1'b1}};
      ctrl_pin_out <= {CTRL_W{1'b0}};
      ctrl_pin_oe_n <= {CTRL_W{1'b1}};
      mem_data_in <= {DATA_W{1'b0}};
      mem_ctrl_in <= {CTRL_W{1'b0}};
      host_address_bits <= {HW{1'b0}};
      host_data_bits <= {HW{1'b0}};
      host_ctrl <= {`PPM_HOST_CTRL_W{1'b0}};
      parallel_general_io_in <= {GPIO_W{1'b0}};
      mem_enable <= 1'b0;
      mem_clk_enable <= 1'b0;
      host_port_enable <= 1'b0;
      host_mux_mode <= 1'b0;
      mem_bus_error <= 1'b0;
    end else begin
      addr_pin_out <= next_addr_out;
      addr_pin_oe_n <= next_addr_oe_n;
      data_pin_out <= next_data_out;
      data_pin_oe_n <= next_data_oe_n;
      ctrl_pin_out <= next_ctrl_out;
      ctrl_pin_oe_n <= next_ctrl_oe_n;
      parallel_general_io_in <= next_gpio_in;
      // deselected cores see idle zeros, except host_ctrl, which always follows its pins
      mem_data_in <= pick(mode_full, data_sync, {DATA_W{1'b0}});
      mem_ctrl_in <= mode_full ? ctrl_sync : {CTRL_W{1'b0}};
      host_address_bits <= mode_full ? {HW{1'b0}} : addr_sync[HW-1:0];
      host_data_bits <= mode_full ? {HW{1'b0}} : data_sync[HW-1:0];
      host_ctrl <= host_ctrl_sync;
      mem_enable <= mode_full;
      mem_clk_enable <= mode_full;
      host_port_enable <= 1'b1;
      host_mux_mode <= mode_full;
      mem_bus_error <= mem_access_req & ~mode_full
        & peripheral_timeout_enable;
    end
  end

endmodule // ppm_parallel_mux

// >>> ppm_parallel_mux_monitor.sv
// timing checks on the parallel pin group multiplexer ports
`timescale 1ns/100ps
module ppm_parallel_mux_monitor (
  input wire core_clk,
  input wire reset_n,
  input wire mem_access_req,
  input wire peripheral_timeout_enable,
  input wire mem_bus_error,
  input wire mem_clk_enable,
  input wire mem_enable,
  input wire host_mux_mode,
  input wire bus_sel_parallel_mode,
  input wire [19:0] addr_pin_out,
  input wire [19:0] addr_pin_oe_n,
  input wire [19:0] mem_addr,
  input wire [31:0] data_pin_out,
  input wire [15:0] host_data_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  reg live;
  // live goes high at the first clock edge that samples reset released
  always @(posedge core_clk) live <= reset_n;
  wire err_due = mem_access_req && peripheral_timeout_enable
    && !bus_sel_parallel_mode;
  a_mode_frozen: assert property (
    live |-> $stable(bus_sel_parallel_mode))
    else $error("mode bit changed after reset");
  a_mem_sel: assert property (
    live |-> mem_enable == bus_sel_parallel_mode)
    else $error("memory enable disagrees with mode");
  a_clk_gate: assert property (live |-> mem_clk_enable == mem_enable)
    else $error("memory clock runs while deselected");
  a_host_muxed: assert property (
    live |-> host_mux_mode == bus_sel_parallel_mode)
    else $error("host mux mode disagrees with mode");
  a_err_pulse: assert property (live && err_due |=> mem_bus_error)
    else $error("missing bus error");
  a_err_none: assert property (live && !err_due |=> !mem_bus_error)
    else $error("spurious bus error");
  a_full_addr: assert property (live && bus_sel_parallel_mode
    |=> addr_pin_out == $past(mem_addr))
    else $error("address pins not from memory interface");
  a_host_data: assert property (live && !bus_sel_parallel_mode
    |=> data_pin_out[15:0] == $past(host_data_out)
    && &addr_pin_oe_n[15:0])
    else $error("host pins misrouted");
endmodule // ppm_parallel_mux_monitor
bind ppm_parallel_mux ppm_parallel_mux_monitor i_ppm_parallel_mux_monitor (.*);

// >>> ppm_pin_model.sv
// far-side board model: resolves each pin from both parties' drive
`timescale 1ns/100ps
module ppm_pin_model (
  input wire [19:0] addr_pin_out,
  input wire [19:0] addr_pin_oe_n,
  input wire [19:0] ext_a,
  output wire [19:0] addr_pin_in,
  input wire [31:0] data_pin_out,
  input wire [31:0] data_pin_oe_n,
  input wire [31:0] ext_d,
  output wire [31:0] data_pin_in,
  input wire [15:0] ctrl_pin_out,
  input wire [15:0] ctrl_pin_oe_n,
  input wire [15:0] ext_c,
  output wire [15:0] ctrl_pin_in
);
  // released bits show the far side's own value, changed every test step
  assign addr_pin_in = addr_pin_oe_n & ext_a | ~addr_pin_oe_n & addr_pin_out;
  assign data_pin_in = data_pin_oe_n & ext_d | ~data_pin_oe_n & data_pin_out;
  assign ctrl_pin_in = ctrl_pin_oe_n & ext_c | ~ctrl_pin_oe_n & ctrl_pin_out;
endmodule // ppm_pin_model

// >>> test_ppm_parallel_mux.sv
// self-checking bench for the parallel pin group multiplexer
`timescale 1ns/100ps
module test_ppm_parallel_mux;
  logic core_clk = 0, reset_n = 0, host_config_strap = 0;
  logic serial_config_strap = 0, mem_access_req = 0, host_data_oe_n = 1;
  logic peripheral_timeout_enable = 0;
  logic [19:0] addr_pin_in, addr_pin_out, addr_pin_oe_n;
  logic [19:0] mem_addr = 0, mem_addr_oe_n = 0, ext_a = 0;
  logic [31:0] data_pin_in, data_pin_out, data_pin_oe_n, mem_data_in;
  logic [31:0] mem_data_out = 0, mem_data_oe_n = 0, ext_d = 0;
  logic [15:0] ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe_n, mem_ctrl_in;
  logic [15:0] mem_ctrl_out = 0, mem_ctrl_oe_n = 0, ext_c = 0;
  logic [15:0] host_address_bits, host_data_bits, host_data_out = 0;
  logic [8:0] host_ctrl, host_ctrl_pin_in = 0;
  logic [35:0] parallel_general_io_in;
  logic [35:0] parallel_general_io_out = 0, parallel_general_io_oe_n = 0;
  logic mem_bus_error, mem_clk_enable, mem_enable, host_port_enable;
  logic host_mux_mode, bus_sel_parallel_mode, bus_sel_serial_mode;
  logic [31:0] seed = 32'h0000_005f;
  logic [127:0] v;
  logic m, sm;
  int err_total = 0, cmp_count = 0;
  ppm_parallel_mux i_ppm_parallel_mux (.*);
  ppm_pin_model i_ppm_pin_model (.*);
  initial forever #5 core_clk = ~core_clk;
  function logic [127:0] r128();
    for (int i = 0; i < 4; i++) begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      r128 = {r128[95:0], seed};
    end
  endfunction
  task chk(input logic [67:0] got, input logic [67:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task check_route();
    logic [67:0] eo, en, r;
    logic [35:0] go, ge;
    go = parallel_general_io_out;
    ge = parallel_general_io_oe_n;
    eo = m ? {mem_addr, mem_data_out, mem_ctrl_out} :
      {go[3:0], 16'h0000, go[19:4], host_data_out, go[35:20]};
    en = m ? {mem_addr_oe_n, mem_data_oe_n, mem_ctrl_oe_n} :
      {ge[3:0], 16'hffff, ge[19:4], {16{host_data_oe_n}}, ge[35:20]};
    r = en & {ext_a, ext_d, ext_c} | ~en & eo;
    chk({addr_pin_out, data_pin_out, ctrl_pin_out}, eo);
    chk({addr_pin_oe_n, data_pin_oe_n, ctrl_pin_oe_n}, en);
    if (m) begin
      chk({mem_data_in, mem_ctrl_in}, r[47:0]);
      chk({host_address_bits, host_data_bits}, 0);
      chk(parallel_general_io_in, 0);
    end else begin
      chk({mem_data_in, mem_ctrl_in}, 0);
      chk(host_address_bits, r[63:48]);
      chk(host_data_bits, r[31:16]);
      chk(host_ctrl, host_ctrl_pin_in);
      chk(parallel_general_io_in, {r[15:0], r[47:32], r[67:64]});
    end
  endtask
  initial begin
    #100000;
    err_total++;
    final_report();
  end
  initial begin
    for (int k = 0; k < 3; k++) begin
      v = r128();
      m = k[0];
      sm = v[0];
      @(negedge core_clk);
      reset_n = 0;
      host_config_strap = m;
      serial_config_strap = sm;
      repeat (16) @(negedge core_clk);
      chk({addr_pin_oe_n, data_pin_oe_n, ctrl_pin_oe_n}, {68{1'b1}});
      // straps are flipped after release; the mode must stay as caught in reset
      reset_n = 1;
      host_config_strap = ~m;
      serial_config_strap = ~sm;
      for (int i = 0; i < 40; i++) begin
        v = r128();
        {mem_addr, mem_addr_oe_n, ext_a} = v[59:0];
        {mem_ctrl_out, mem_ctrl_oe_n, ext_c} = v[107:60];
        {host_data_out, host_data_oe_n} = v[124:108];
        v = r128();
        {mem_data_out, mem_data_oe_n, ext_d} = v[95:0];
        host_ctrl_pin_in = v[104:96];
        v = r128();
        {parallel_general_io_out, parallel_general_io_oe_n} = v[71:0];
        // corner cases: everything driven, then everything released
        if (i < 2) begin
          {mem_addr_oe_n, mem_data_oe_n, mem_ctrl_oe_n} = {68{i[0]}};
          {parallel_general_io_oe_n, host_data_oe_n} = {37{i[0]}};
        end
        repeat (5) @(negedge core_clk);
        check_route();
      end
      chk(bus_sel_parallel_mode, m);
      chk({bus_sel_serial_mode, mem_enable}, {sm, m});
      chk({mem_clk_enable, host_mux_mode, host_port_enable},
        {m, m, 1'b1});
      for (int te = 0; te < 2; te++) begin
        peripheral_timeout_enable = te[0];
        mem_access_req = 1;
        repeat (2) begin
          @(negedge core_clk);
          chk(mem_bus_error, ~m & te[0]);
        end
        mem_access_req = 0;
        @(negedge core_clk);
        chk(mem_bus_error, 0);
      end
      $display("mode test %0d done", k);
    end
    final_report();
  end
endmodule // test_ppm_parallel_mux
